// ==== src/scrs_sequencer.v ====
// Behaviour
// - Ratio pins pick startup multiplier 8, 32, 16.
// - Software may rewrite multiplier/divider after reset.
// - Hold core 4096 cycles, then start at vector.
// - Shared pin outputs reset unless control bit set.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`include "scrs_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module scrs_sequencer #(
	parameter LOCK_CYCLES = `SCRS_LOCK_CYCLES,
	parameter VECTOR      = 32'h00000000
) (
	input  wire        mclk,
	input  wire        srst,
	input  wire        reset_in_n,
	input  wire [1:0]  ratio_pins,
	input  wire [2:0]  boot_pins,
	input  wire        shared_pin_in,
	output reg         shared_pin_out,
	output reg         shared_pin_oe,
	output reg         core_reset,
	output reg         core_start,
	output reg  [31:0] start_address,
	output reg  [2:0]  boot_mode,
	output reg  [6:0]  pll_mult,
	output reg  [1:0]  pll_div,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	localparam ST_RESET = 2'h0;
	localparam ST_LOCK  = 2'h1;
	localparam ST_RUN   = 2'h2;

	reg  [1:0]  state;
	reg  [12:0] lock_count;
	reg  [1:0]  rst_sync;
	reg  [1:0]  run_sync;
	reg  [1:0]  ratio_sync0;
	reg  [1:0]  ratio_sync1;
	reg  [2:0]  boot_sync0;
	reg  [2:0]  boot_sync1;
	reg         runrst_en;
	reg  [11:0] aw_addr;
	reg         aw_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         w_held;
	wire        ext_reset;
	wire        run_reset;
	wire        wr_go;
	wire        lock_done;
	wire        next_core_reset;
	wire [31:0] pmc_merged;

	// Ratio code to multiplier; the reserved code falls back to the slowest ratio.
	function [6:0] ratio_mult;
		input [1:0] code;
		begin
			case (code)
				`SCRS_RATIO_8:  ratio_mult = 7'h08;
				`SCRS_RATIO_32: ratio_mult = 7'h20;
				`SCRS_RATIO_16: ratio_mult = 7'h10;
				default:        ratio_mult = 7'h08;
			endcase
		end
	endfunction

	// Byte-lane merge used by the power management register write.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// Every pin input passes two flip-flops before use.
	always @(posedge mclk)
	begin
		rst_sync    <= {rst_sync[0], ~reset_in_n};
		run_sync    <= {run_sync[0], ~shared_pin_in};
		ratio_sync0 <= ratio_pins;
		ratio_sync1 <= ratio_sync0;
		boot_sync0  <= boot_pins;
		boot_sync1  <= boot_sync0;
	end

	assign ext_reset = rst_sync[1];
	assign run_reset = runrst_en & run_sync[1];

	// Next hold value, so the pin enable moves on the same edge as the hold itself.
	assign lock_done       = (state == ST_LOCK) && (lock_count == LOCK_CYCLES - 1);
	assign next_core_reset = srst | ext_reset | run_reset | (core_reset & ~lock_done);

	// Reset, lock wait and run sequence.
	always @(posedge mclk)
	begin
		core_start <= 1'b0;
		if (srst || ext_reset || run_reset)
		begin
			state      <= ST_RESET;
			lock_count <= 13'h0000;
			core_reset <= 1'b1;
			// Boot pins are valid before reset, so they are captured while it is held.
			boot_mode  <= boot_sync1;
		end
		else
		begin
			case (state)
				ST_RESET:
				begin
					state      <= ST_LOCK;
					lock_count <= 13'h0000;
				end
				ST_LOCK:
				begin
					if (lock_done)
					begin
						state         <= ST_RUN;
						core_reset    <= 1'b0;
						core_start    <= 1'b1;
						start_address <= VECTOR;
					end
					else
						lock_count <= lock_count + 13'h0001;
				end
				ST_RUN:
					state <= ST_RUN;
				default:
					state <= ST_RESET;
			endcase
		end
		if (srst)
		begin
			start_address <= 32'h00000000;
			boot_mode     <= 3'h0;
		end
	end

	// Shared pin drives reset low while the core is held, including lock wait, unless running reset is enabled.
	always @(posedge mclk)
	begin
		if (srst)
		begin
			shared_pin_out <= 1'b0;
			shared_pin_oe  <= 1'b1;
		end
		else
		begin
			shared_pin_out <= 1'b0;
			// A registered copy of the hold would lag it by one edge and drive the pin
			// after the core is already running.
			shared_pin_oe  <= ~runrst_en & next_core_reset;
		end
	end

	// Write channel: address and data are taken in either order.
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_go         = aw_held & w_held & ~s_axi_bvalid;

	// Byte-lane merge of a power management write into the current settings.
	assign pmc_merged = merge({22'h0, pll_div, 1'b0, pll_mult}, w_data, w_strb);

	always @(posedge mclk)
	begin
		if (srst)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 12'h000;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SCRS_RESP_OKAY;
			runrst_en    <= 1'b0;
			pll_mult     <= 7'h08;
			pll_div      <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// Startup ratio loads the multiplier each time the core is held.
			if (core_reset)
				pll_mult <= ratio_mult(ratio_sync1);
			if (wr_go)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SCRS_RESP_OKAY;
				case (aw_addr)
					`SCRS_OFF_PMC:
						// Writes while the core is held are dropped; the pins own the ratio then.
						if (!core_reset)
						begin
							pll_mult <= pmc_merged[`SCRS_PMC_MULT_LSB +: `SCRS_PMC_MULT_W];
							pll_div  <= pmc_merged[`SCRS_PMC_DIV_LSB +: `SCRS_PMC_DIV_W];
						end
					`SCRS_OFF_RUNRST:
						if (w_strb[0])
							runrst_en <= w_data[`SCRS_RUNRST_EN_BIT];
					`SCRS_OFF_STATUS:
						s_axi_bresp <= `SCRS_RESP_OKAY;
					default:
						s_axi_bresp <= `SCRS_RESP_SLVERR;
				endcase
			end
		end
	end

	// Read channel answers one cycle after the address is taken.
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge mclk)
	begin
		if (srst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `SCRS_RESP_OKAY;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else if (s_axi_arvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `SCRS_RESP_OKAY;
			case (s_axi_araddr)
				`SCRS_OFF_PMC:
					s_axi_rdata <= {22'h0, pll_div, 1'b0, pll_mult};
				`SCRS_OFF_RUNRST:
					s_axi_rdata <= {31'h0, runrst_en};
				`SCRS_OFF_STATUS:
					s_axi_rdata <= {24'h0, boot_mode, ratio_sync1, state, core_reset};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SCRS_RESP_SLVERR;
				end
			endcase
		end
	end

endmodule // scrs_sequencer

`default_nettype wire

// ==== src/scrs_regs.vh ====
`ifndef SCRS_REGS_VH
`define SCRS_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define SCRS_OFF_PMC        12'h000
`define SCRS_OFF_RUNRST     12'h004
`define SCRS_OFF_STATUS     12'h008

// Power management control fields: multiplier in [6:0], divider in [9:8].
`define SCRS_PMC_MULT_LSB   0
`define SCRS_PMC_MULT_W     7
`define SCRS_PMC_DIV_LSB    8
`define SCRS_PMC_DIV_W      2
`define SCRS_PMC_RESET      32'h00000008

// Running reset control: bit 0 turns the shared pin into an input.
`define SCRS_RUNRST_EN_BIT  0

// Startup ratio pin codes.
`define SCRS_RATIO_8        2'h0
`define SCRS_RATIO_32       2'h1
`define SCRS_RATIO_16       2'h2
`define SCRS_RATIO_RSVD     2'h3

// Lock wait in input clock cycles.
`define SCRS_LOCK_CYCLES    4096

// AXI response codes.
`define SCRS_RESP_OKAY      2'h0
`define SCRS_RESP_SLVERR    2'h2

`endif

// ==== sim/scrs_sequencer_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module scrs_sequencer_chk #(
	parameter LOCK_CYCLES = 4096,
	parameter VECTOR      = 32'h00000000
) (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        reset_in_n,
	input wire logic [1:0]  ratio_pins,
	input wire logic        shared_pin_out,
	input wire logic        shared_pin_oe,
	input wire logic        core_reset,
	input wire logic        core_start,
	input wire logic [31:0] start_address,
	input wire logic [6:0]  pll_mult
);
	// Length of the current hold; saturates so a long hold cannot wrap to a short one.
	logic [15:0] held;
	always_ff @(posedge mclk)
		held <= (srst || !core_reset) ? 16'h0000 : held + {15'h0000, ~&held};
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence leave_s;
		$fell(core_reset) ##1 !core_start;
	endsequence
	chk_lock_wait: assert property (core_start |-> held >= LOCK_CYCLES)
		else $error("core left reset before the lock wait ended");
	chk_start_pulse: assert property (core_start |-> leave_s)
		else $error("start is not a single pulse at reset exit");
	chk_fall_start: assert property ($fell(core_reset) |-> core_start)
		else $error("core left reset without a start pulse");
	chk_vector_out: assert property (core_start |=> start_address == VECTOR)
		else $error("start address is not the reset vector");
	chk_reset_grab: assert property ($fell(reset_in_n) |-> ##[1:3] core_reset)
		else $error("board reset did not hold the core");
	chk_pin_drive: assert property (shared_pin_oe |-> core_reset && !shared_pin_out)
		else $error("shared pin driven outside reset");
	chk_hold_out: assert property (shared_pin_oe && core_reset |=> shared_pin_oe || !core_reset)
		else $error("reset output dropped while core held");
	chk_mult_map: assert property (core_start |-> pll_mult == ((ratio_pins == 2'h1) ? 7'h20 :
		(ratio_pins == 2'h2) ? 7'h10 : 7'h08)) else $error("startup multiplier wrong");
endmodule // scrs_sequencer_chk
`default_nettype wire

// ==== sim/scrs_board.sv ====
`timescale 1ns/10ps
`default_nettype none
module scrs_board (
	input  wire logic       mclk,
	input  wire logic       hold,
	input  wire logic       pull_low,
	input  wire logic [1:0] rat,
	input  wire logic [2:0] boot,
	input  wire logic       pin_out,
	input  wire logic       pin_oe,
	output var  logic       reset_in_n = 1'b0,
	output var  logic [1:0] ratio_pins = 2'h0,
	output var  logic [2:0] boot_pins = 3'h0,
	output wire logic       pin_level
);
	// Straps are set by the bench a cycle before it asks for reset.
	always @(posedge mclk)
	begin
		ratio_pins <= rat;
		boot_pins <= boot;
		reset_in_n <= !hold;
	end
	// The pin has a pull-up, so it never floats to a stale level.
	assign pin_level = !(pin_oe && !pin_out) && !pull_low;
endmodule // scrs_board
`default_nettype wire

// ==== sim/tb_scrs_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "scrs_regs.vh"
`define CMP(n, e, s) begin exp_v = e; n_compared++; if (exp_v !== (s)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", n, exp_v, s); end end
module tb_scrs_sequencer;
	localparam LOCK = 16;
	logic        mclk = 1'b0, srst = 1'b1, hold = 1'b1, pull_low = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, start_address, exp_v, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  rat = 2'h0, ratio_pins, s_axi_bresp, s_axi_rresp, pll_div;
	logic [2:0]  boot = 3'h0, boot_pins, boot_mode, bt;
	logic [6:0]  pll_mult;
	logic        reset_in_n, shared_pin_in, shared_pin_out, shared_pin_oe, core_reset, core_start;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          num_errors = 0, n_compared = 0;
	logic [31:0] exp_q[$];
	always #2 mclk = ~mclk;
	scrs_sequencer #(.LOCK_CYCLES(LOCK)) dut (.*);
	scrs_board board (.mclk, .hold, .pull_low, .rat, .boot, .pin_out(shared_pin_out),
		.pin_oe(shared_pin_oe), .reset_in_n, .ratio_pins, .boot_pins, .pin_level(shared_pin_in));
	// Each result that shows up takes the oldest note off the queue.
	always @(posedge mclk)
	begin
		if (core_start) `CMP("start", exp_q.pop_front(), {22'h0, boot_mode, pll_mult})
		if (s_axi_bvalid && s_axi_bready) `CMP("bresp", exp_q.pop_front(), {30'h0, s_axi_bresp})
		if (s_axi_rvalid && s_axi_rready) `CMP("rdata", exp_q.pop_front(), s_axi_rdata)
		if (s_axi_rvalid && s_axi_rready) `CMP("rresp", exp_q.pop_front(), {30'h0, s_axi_rresp})
	end
	task end_of_test;
		if (num_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
		exp_q.push_back({30'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		// One idle edge keeps a following call from raising bready in this time step.
		@(posedge mclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
		exp_q.push_back(e);
		exp_q.push_back({30'h0, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask
	// Straps settle first, then reset is pulsed and the start is awaited.
	task boot_core(input logic [1:0] c, input logic [2:0] b);
		rat <= c;
		boot <= b;
		@(posedge mclk);
		hold <= 1'b1;
		repeat (4) @(posedge mclk);
		exp_q.push_back({22'h0, b, c == 2'h1 ? 7'h20 : c == 2'h2 ? 7'h10 : 7'h08});
		hold <= 1'b0;
		for (int i = 0; i < LOCK + 20 && !core_start; i++) @(posedge mclk);
		`CMP("started", 32'h1, {31'h0, core_start})
		@(posedge mclk);
	endtask
	initial
	begin
		void'($urandom(60));
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			bt = 3'($urandom_range(7));
			boot_core(c[1:0], bt);
		end
		// Status after the last start: boot pins, reserved ratio code, running, released.
		rd(`SCRS_OFF_STATUS, {24'h0, bt, 2'h3, 2'h2, 1'b0}, `SCRS_RESP_OKAY);
		d = $urandom;
		wr(`SCRS_OFF_PMC, d, `SCRS_RESP_OKAY);
		rd(`SCRS_OFF_PMC, d & 32'h0000037F, `SCRS_RESP_OKAY);
		rd(12'hFFC, 32'h00000000, `SCRS_RESP_SLVERR);
		wr(12'hFFC, d, `SCRS_RESP_SLVERR);
		wr(`SCRS_OFF_RUNRST, 32'h00000001, `SCRS_RESP_OKAY);
		rd(`SCRS_OFF_RUNRST, 32'h00000001, `SCRS_RESP_OKAY);
		pull_low <= 1'b1;
		repeat (5) @(posedge mclk);
		`CMP("running reset", 32'h1, {31'h0, core_reset})
		end_of_test;
	end
	// Cuts a hang short well past the expected run length.
	initial
	begin
		#100000;
		num_errors++;
		end_of_test;
	end
endmodule // tb_scrs_sequencer
bind scrs_sequencer scrs_sequencer_chk #(.LOCK_CYCLES(LOCK_CYCLES), .VECTOR(VECTOR)) chk (.*);
`default_nettype wire
